// ### shared/cad_params.svh
/*
  Constants for the communications accelerator datapath: register-file size,
  configuration reset values and pipeline depths.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CAD_PARAMS_SVH
`define CAD_PARAMS_SVH

`define CAD_VR_COUNT      9
`define CAD_VR_IDX_W      4
`define CAD_DATA_W        32
`define CAD_POLY_RST      32'h0000_0000
`define CAD_CRC_RST       32'h0000_0000
`define CAD_DSIZE_RST     3'h7
`define CAD_PSIZE_RST     5'h1F
`define CAD_KLEN_RST      3'h7
`define CAD_KLEN_MIN      3'h4
`define CAD_KLEN_MAX      3'h7
`define CAD_RPT_W         16
`define CAD_BM2_CYC       1
`define CAD_BM3_CYC       2
`define CAD_ACS_CYC       2
`define CAD_TB_CYC        3
`define CAD_MUL_CYC       2

`endif

// ### shared/cad_pkg.sv
/*
  Types of the communications accelerator datapath: instruction codes,
  pipeline slot kinds and the packed state of the top module.
  Assumes cad_params.svh is on the include path.
*/
`include "cad_params.svh"

package cad_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_LD32, OP_ST32, OP_LDPOLY, OP_LDSIZE, OP_SETCFG, OP_LDCRC, OP_STCRC,
    OP_CRCL, OP_CRCH, OP_CRCSWAP, OP_CADD32, OP_CSUB32, OP_CADD16, OP_CSUB16,
    OP_CMPY, OP_CMAC, OP_RPTMAC, OP_BM2, OP_BM3, OP_ACS, OP_TRACE
  } cad_op_t;

  typedef enum logic [2:0] {
    PK_NONE, PK_MUL, PK_MAC, PK_BM3, PK_ACS, PK_TB
  } cad_pk_t;

  typedef struct packed {
    logic [`CAD_VR_COUNT-1:0][31:0] vr;
    logic [31:0]                    vt0;
    logic [31:0]                    vt1;
    logic [31:0]                    crc;
    logic [31:0]                    poly;
    logic [2:0]                     dsize;
    logic [4:0]                     psize;
    logic                           flip;
    logic [2:0]                     klen;
    logic [`CAD_RPT_W-1:0]          rpt_cnt;
    logic [`CAD_VR_IDX_W-1:0]       rpt_src;
    logic [`CAD_VR_IDX_W-1:0]       rpt_dst;
    cad_pk_t                        s1_kind;
    logic [`CAD_VR_IDX_W-1:0]       s1_dst;
    logic [3:0][31:0]               s1_val;
    cad_pk_t                        s2_kind;
    logic [`CAD_VR_IDX_W-1:0]       s2_dst;
    logic [31:0]                    s2_val;
    logic [31:0]                    rd_data;
    logic                           rd_valid;
    logic                           busy;
  } cad_state_t;

endpackage : cad_pkg

// ### rtl/cad_crc_step.sv
/*
  One CRC step: folds up to eight data bits of a 16-bit word into a running
  CRC of configurable width. Pure combinational.
  Assumes the caller registers the result in its CRC result register.
*/
`include "cad_params.svh"

module cad_crc_step (
  input  wire logic [31:0] crc_in,
  input  wire logic [31:0] poly_in,
  input  wire logic [4:0]  psize_in,
  input  wire logic [2:0]  dsize_in,
  input  wire logic [15:0] data_in,
  input  wire logic        high_in,
  input  wire logic        flip_in,
  output logic      [31:0] crc_out
);

  logic [7:0]  sel;
  logic [7:0]  temp;
  logic [31:0] acc;
  logic [31:0] mask;
  logic        fb;

  always_comb begin
    sel  = high_in ? data_in[15:8] : data_in[7:0];
    temp = sel;
    // RQ19 reverse data bits
    if (flip_in) begin
      for (int i = 0; i < 8; i++) begin
        if (i <= int'(dsize_in)) begin
          temp[i] = sel[int'(dsize_in) - i];
        end
      end
    end
    mask = (psize_in == 5'h1F) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (psize_in + 5'h01)) - 32'h1);
    acc  = crc_in & mask;
    fb   = 1'b0;
    // RQ18 fold selected bits, msb first
    for (int i = 7; i >= 0; i--) begin
      if (i <= int'(dsize_in)) begin
        fb  = acc[psize_in] ^ temp[i];
        acc = (acc << 1) & mask;
        if (fb) begin
          acc = acc ^ (poly_in & mask);
        end
      end
    end
    crc_out = acc;
  end

endmodule : cad_crc_step

// ### rtl/cad_datapath.sv
/*
  Communications accelerator datapath: own register file, CRC unit,
  Viterbi branch-metric / butterfly / traceback, complex arithmetic.
  Assumes a host core issues one instruction per cycle on op_valid_in and
  supplies memory operands on mem_data_in; it schedules around the pipeline.
*/
// How it works
// RQ1 - Rate one-half branch metric finishes in one cycle.
// RQ2 - Rate one-third branch metric finishes over two pipelined cycles.
// RQ3 - Butterfly takes two cycles, one traceback stage takes three.
// RQ4 - Viterbi handles constraint length four to seven, rates half and third.
// RQ5 - CRC polynomial widths of 8, 16, 24 and 32 bits supported.
// RQ6 - Dedicated CRC register holds running value, updated by each CRC op.
// RQ7 - CRC consumes one byte per cycle.
// RQ8 - Complex multiply of four real products in one cycle.
// RQ9 - Both 16-bit halves of a complex value move in one cycle.
// RQ10 - Complex 32-bit add or subtract gives 32-bit parts in one cycle.
// RQ11 - Mixed 16 and 32-bit complex add or subtract gives 15-bit parts.
// RQ12 - 16x16 complex multiply gives 32-bit parts over two cycles; MAC accumulates.
// RQ13 - Repeated MAC: two cycles for the first, one per further operation.
// RQ14 - Runs on the host system clock.
// RQ15 - No interlock; host must space dependent instructions itself.
// RQ16 - Host instruction behaviour, pipeline and buses stay unchanged.
// RQ17 - Own register space for operands and results.
// RQ18 - CRC step folds configured data bits with configured polynomial and size.
// RQ19 - Bit-reverse flag reverses selected data bits before folding.
// RQ20 - Registers not named as destination stay unchanged.
`include "cad_params.svh"

module cad_datapath #(
  parameter int RPT_W = `CAD_RPT_W
) (
  // RQ14 single host clock
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       op_valid_in,
  input  wire cad_pkg::cad_op_t           op_code_in,
  input  wire logic [`CAD_VR_IDX_W-1:0]   dst_in,
  input  wire logic [`CAD_VR_IDX_W-1:0]   src_a_in,
  input  wire logic [`CAD_VR_IDX_W-1:0]   src_b_in,
  input  wire logic [31:0]                mem_data_in,
  input  wire logic [RPT_W-1:0]           rpt_count_in,
  output logic      [31:0]                rd_data_out,
  output logic                            rd_valid_out,
  output logic      [31:0]                crc_out,
  output logic                            busy_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic in_rf(input logic [`CAD_VR_IDX_W-1:0] idx);
    in_rf = (idx < `CAD_VR_IDX_W'(`CAD_VR_COUNT));
  endfunction : in_rf

  // RQ17 out-of-range index reads zero
  function automatic logic [31:0] vr_rd(input logic [`CAD_VR_COUNT-1:0][31:0] rf,
                                        input logic [`CAD_VR_IDX_W-1:0]      idx);
    vr_rd = in_rf(idx) ? rf[idx] : 32'h0000_0000;
  endfunction : vr_rd

  function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
    max16 = ($signed(a) >= $signed(b)) ? a : b;
  endfunction : max16

  function automatic logic [31:0] smul16(input logic [15:0] a, input logic [15:0] b);
    smul16 = 32'($signed(a) * $signed(b));
  endfunction : smul16

  // Mixed add: 16-bit part against high half of 32-bit part, divided by four to 15 bits
  function automatic logic [15:0] mix15(input logic [15:0] a, input logic [31:0] b,
                                        input logic sub);
    logic [16:0] s;
    s = sub ? 17'($signed(a) - $signed(b[31:16])) : 17'($signed(a) + $signed(b[31:16]));
    mix15 = {s[16], s[16:2]};
  endfunction : mix15

  ////////////////////////////////////////////////////////////////////////////
  // State

  cad_pkg::cad_state_t s_q;
  cad_pkg::cad_state_t s_d;
  cad_pkg::cad_state_t rst_state;
  logic [31:0]         crc_next;
  logic [31:0]         a_val;
  logic [31:0]         b_val;
  logic [31:0]         b_hi;
  logic [31:0]         a_hi;
  logic                crc_hi;
  logic [15:0]         bm;
  logic [5:0]          tb_mask;
  logic [`CAD_VR_IDX_W-1:0] dst_hi;
  logic [`CAD_VR_IDX_W-1:0] mul_src;
  logic [31:0]         mul_b;
  logic                mul_go;
  logic                mul_acc;

  always_comb begin
    rst_state       = '0;
    rst_state.poly  = `CAD_POLY_RST;
    rst_state.crc   = `CAD_CRC_RST;
    rst_state.dsize = `CAD_DSIZE_RST;
    rst_state.psize = `CAD_PSIZE_RST;
    rst_state.klen  = `CAD_KLEN_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC step

  assign crc_hi = (op_code_in == cad_pkg::OP_CRCH);

  // RQ7 one byte per cycle
  cad_crc_step u_crc_step (
    .crc_in   (s_q.crc),
    .poly_in  (s_q.poly),
    .psize_in (s_q.psize),
    .dsize_in (s_q.dsize),
    .data_in  (mem_data_in[15:0]),
    .high_in  (crc_hi),
    .flip_in  (s_q.flip),
    .crc_out  (crc_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    // RQ20 unnamed registers hold
    s_d          = s_q;
    s_d.rd_valid = 1'b0;
    a_val        = vr_rd(s_q.vr, src_a_in);
    b_val        = vr_rd(s_q.vr, src_b_in);
    a_hi         = vr_rd(s_q.vr, src_a_in + `CAD_VR_IDX_W'(1));
    b_hi         = vr_rd(s_q.vr, src_b_in + `CAD_VR_IDX_W'(1));
    dst_hi       = dst_in + `CAD_VR_IDX_W'(1);
    bm           = b_val[15:0];
    // RQ4 constraint length 4..7 sets state width K-1
    tb_mask      = 6'((7'h01 << (s_q.klen - 3'h1)) - 7'h01);
    mul_go       = 1'b0;
    mul_acc      = 1'b0;
    mul_src      = src_a_in;
    mul_b        = mem_data_in;

    // Stage 2 writeback of stage-1 slot; issue writes override stage writebacks
    s_d.s2_kind = cad_pkg::PK_NONE;
    case (s_q.s1_kind)
      cad_pkg::PK_MUL, cad_pkg::PK_MAC: begin
        // RQ12 combine products, optional accumulate
        if (in_rf(s_q.s1_dst)) begin
          s_d.vr[s_q.s1_dst] = s_q.s1_val[0] - s_q.s1_val[1]
                               + ((s_q.s1_kind == cad_pkg::PK_MAC) ? s_q.vr[s_q.s1_dst] : '0);
        end
        if (in_rf(s_q.s1_dst + `CAD_VR_IDX_W'(1))) begin
          s_d.vr[s_q.s1_dst + `CAD_VR_IDX_W'(1)] = s_q.s1_val[2] + s_q.s1_val[3]
            + ((s_q.s1_kind == cad_pkg::PK_MAC) ? s_q.vr[s_q.s1_dst + `CAD_VR_IDX_W'(1)] : '0);
        end
      end
      cad_pkg::PK_BM3: begin
        // RQ2 second stage folds third symbol
        if (in_rf(s_q.s1_dst)) begin
          s_d.vr[s_q.s1_dst] = {s_q.s1_val[0][15:0] - s_q.s1_val[2][15:0],
                                s_q.s1_val[0][15:0] + s_q.s1_val[2][15:0]};
        end
        if (in_rf(s_q.s1_dst + `CAD_VR_IDX_W'(1))) begin
          s_d.vr[s_q.s1_dst + `CAD_VR_IDX_W'(1)] =
            {s_q.s1_val[1][15:0] - s_q.s1_val[2][15:0],
             s_q.s1_val[1][15:0] + s_q.s1_val[2][15:0]};
        end
      end
      cad_pkg::PK_ACS: begin
        // RQ3 butterfly select and decisions
        if (in_rf(s_q.s1_dst)) begin
          s_d.vr[s_q.s1_dst] = {max16(s_q.s1_val[2][15:0], s_q.s1_val[3][15:0]),
                                max16(s_q.s1_val[0][15:0], s_q.s1_val[1][15:0])};
        end
        s_d.vt0 = {s_q.vt0[29:0],
                   $signed(s_q.s1_val[3][15:0]) > $signed(s_q.s1_val[2][15:0]),
                   $signed(s_q.s1_val[1][15:0]) > $signed(s_q.s1_val[0][15:0])};
      end
      cad_pkg::PK_TB: begin
        // RQ3 traceback second stage: next state
        s_d.s2_kind = cad_pkg::PK_TB;
        s_d.s2_dst  = s_q.s1_dst;
        s_d.s2_val  = {26'h0, 6'(({s_q.s1_val[0][4:0], s_q.s1_val[1][0]}) & tb_mask)};
        s_d.vt1     = {s_q.vt1[30:0], s_q.s1_val[1][0]};
      end
      default: begin
      end
    endcase
    // RQ3 traceback third stage writes state
    if (s_q.s2_kind == cad_pkg::PK_TB && in_rf(s_q.s2_dst)) begin
      s_d.vr[s_q.s2_dst] = s_q.s2_val;
    end

    s_d.s1_kind = cad_pkg::PK_NONE;
    s_d.s1_dst  = dst_in;

    if (s_q.rpt_cnt != '0) begin
      // RQ13 repeated MAC one per cycle, issue port ignored
      s_d.rpt_cnt = s_q.rpt_cnt - RPT_W'(1);
      mul_go      = 1'b1;
      mul_acc     = 1'b1;
      mul_src     = s_q.rpt_src;
      s_d.s1_dst  = s_q.rpt_dst;
    // RQ16 only accelerator codes act; host path untouched
    end else if (op_valid_in) begin
      case (op_code_in)
        // RQ9 whole complex word in one cycle
        cad_pkg::OP_LD32: if (in_rf(dst_in)) s_d.vr[dst_in] = mem_data_in;
        cad_pkg::OP_ST32: begin
          s_d.rd_data  = a_val;
          s_d.rd_valid = 1'b1;
        end
        cad_pkg::OP_LDPOLY: s_d.poly = mem_data_in;
        // RQ5 poly size field picks CRC width
        cad_pkg::OP_LDSIZE: begin
          s_d.dsize = mem_data_in[2:0];
          s_d.psize = mem_data_in[20:16];
        end
        cad_pkg::OP_SETCFG: begin
          s_d.flip = mem_data_in[0];
          s_d.klen = (mem_data_in[6:4] < `CAD_KLEN_MIN) ? `CAD_KLEN_MIN : mem_data_in[6:4];
        end
        cad_pkg::OP_LDCRC: s_d.crc = mem_data_in;
        cad_pkg::OP_STCRC: begin
          s_d.rd_data  = s_q.crc;
          s_d.rd_valid = 1'b1;
        end
        // RQ6 every CRC op updates result
        cad_pkg::OP_CRCL, cad_pkg::OP_CRCH: s_d.crc = crc_next;
        cad_pkg::OP_CRCSWAP: s_d.crc = {s_q.crc[31:16], s_q.crc[7:0], s_q.crc[15:8]};
        // RQ10 32-bit parts, one cycle
        cad_pkg::OP_CADD32, cad_pkg::OP_CSUB32: begin
          if (in_rf(dst_in)) begin
            s_d.vr[dst_in] = (op_code_in == cad_pkg::OP_CSUB32) ? a_val - b_val : a_val + b_val;
          end
          if (in_rf(dst_hi)) begin
            s_d.vr[dst_hi] = (op_code_in == cad_pkg::OP_CSUB32) ? a_hi - b_hi : a_hi + b_hi;
          end
        end
        // RQ11 mixed widths give 15-bit parts
        cad_pkg::OP_CADD16, cad_pkg::OP_CSUB16: begin
          if (in_rf(dst_in)) begin
            s_d.vr[dst_in] = {mix15(a_val[31:16], b_hi, op_code_in == cad_pkg::OP_CSUB16),
                              mix15(a_val[15:0], b_val, op_code_in == cad_pkg::OP_CSUB16)};
          end
        end
        cad_pkg::OP_CMPY: mul_go = 1'b1;
        cad_pkg::OP_CMAC: begin
          mul_go  = 1'b1;
          mul_acc = 1'b1;
        end
        cad_pkg::OP_RPTMAC: begin
          mul_go  = 1'b1;
          mul_acc = 1'b1;
          if (rpt_count_in != '0) begin
            s_d.rpt_cnt = rpt_count_in - RPT_W'(1);
          end
          s_d.rpt_src = src_a_in;
          s_d.rpt_dst = dst_in;
        end
        // RQ1 rate half metric in one cycle
        cad_pkg::OP_BM2: begin
          if (in_rf(dst_in)) begin
            s_d.vr[dst_in] = {a_val[15:0] - a_val[31:16], a_val[15:0] + a_val[31:16]};
          end
        end
        cad_pkg::OP_BM3: begin
          s_d.s1_kind   = cad_pkg::PK_BM3;
          s_d.s1_val[0] = {16'h0, a_val[15:0] + a_val[31:16]};
          s_d.s1_val[1] = {16'h0, a_val[15:0] - a_val[31:16]};
          s_d.s1_val[2] = {16'h0, b_val[15:0]};
          s_d.s1_val[3] = '0;
        end
        cad_pkg::OP_ACS: begin
          s_d.s1_kind   = cad_pkg::PK_ACS;
          s_d.s1_val[0] = {16'h0, a_val[15:0] + bm};
          s_d.s1_val[1] = {16'h0, a_val[31:16] - bm};
          s_d.s1_val[2] = {16'h0, a_val[15:0] - bm};
          s_d.s1_val[3] = {16'h0, a_val[31:16] + bm};
        end
        cad_pkg::OP_TRACE: begin
          s_d.s1_kind   = cad_pkg::PK_TB;
          s_d.s1_val[0] = a_val & {26'h0, tb_mask};
          s_d.s1_val[1] = {31'h0, s_q.vt0[a_val[4:0]]};
          s_d.s1_val[2] = '0;
          s_d.s1_val[3] = '0;
        end
        default: begin
        end
      endcase
    end

    // RQ8 four real products in one cycle
    if (mul_go) begin
      a_val         = vr_rd(s_q.vr, mul_src);
      s_d.s1_kind   = mul_acc ? cad_pkg::PK_MAC : cad_pkg::PK_MUL;
      s_d.s1_val[0] = smul16(a_val[15:0], mul_b[15:0]);
      s_d.s1_val[1] = smul16(a_val[31:16], mul_b[31:16]);
      s_d.s1_val[2] = smul16(a_val[15:0], mul_b[31:16]);
      s_d.s1_val[3] = smul16(a_val[31:16], mul_b[15:0]);
    end
    s_d.busy = (s_d.rpt_cnt != '0);
  end

  // RQ15 no interlock: results land at fixed depth regardless of readers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_q <= rst_state;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_out  = s_q.rd_data;
  assign rd_valid_out = s_q.rd_valid;
  assign crc_out      = s_q.crc;
  assign busy_out     = s_q.busy;

endmodule : cad_datapath

// ### sim/cad_checker.sv
/*
  Port assertions for the accelerator datapath.
  Assumes one clock and a synchronous active-high reset; bound to cad_datapath.
*/
module cad_checker #(
  parameter int RPT_W = 16
) (
  input wire logic             ref_clk_in,
  input wire logic             rst_in,
  input wire logic             op_valid_in,
  input wire cad_pkg::cad_op_t op_code_in,
  input wire logic [31:0]      mem_data_in,
  input wire logic [RPT_W-1:0] rpt_count_in,
  input wire logic [31:0]      rd_data_out,
  input wire logic             rd_valid_out,
  input wire logic [31:0]      crc_out,
  input wire logic             busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  logic        tk;
  logic        st_tk;
  logic        crc_tk;
  logic        rpt_tk;
  logic [31:0] crc_sw;
  assign tk     = op_valid_in && !busy_out;
  assign st_tk  = tk && (op_code_in == cad_pkg::OP_ST32 || op_code_in == cad_pkg::OP_STCRC);
  assign crc_tk = tk && (op_code_in inside {cad_pkg::OP_LDCRC, cad_pkg::OP_CRCL,
                                            cad_pkg::OP_CRCH, cad_pkg::OP_CRCSWAP});
  assign rpt_tk = tk && op_code_in == cad_pkg::OP_RPTMAC;
  assign crc_sw = {crc_out[31:16], crc_out[7:0], crc_out[15:8]};

  sequence s_rpt3;
    rpt_tk && rpt_count_in == RPT_W'(3);
  endsequence
  sequence s_busy2;
    busy_out [*2] ##1 !busy_out;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // store, CRC and repeat-busy port checks
  a_store_pulse: assert property (tk && op_code_in == cad_pkg::OP_ST32 |=> rd_valid_out)
    else $error("store gave no read strobe");
  a_read_cause: assert property (rd_valid_out |-> $past(st_tk))
    else $error("read strobe without a store");
  a_crc_report: assert property (tk && op_code_in == cad_pkg::OP_STCRC |=>
    rd_data_out == $past(crc_out)) else $error("CRC store data wrong");
  a_crc_hold: assert property (!crc_tk |=> $stable(crc_out))
    else $error("CRC changed without a CRC instruction");
  a_crc_swap: assert property (tk && op_code_in == cad_pkg::OP_CRCSWAP |=>
    crc_out == $past(crc_sw)) else $error("CRC byte swap wrong");
  a_crc_load: assert property (tk && op_code_in == cad_pkg::OP_LDCRC |=>
    crc_out == $past(mem_data_in)) else $error("CRC load wrong");
  a_rpt_busy_run: assert property (s_rpt3 |=> s_busy2)
    else $error("busy span wrong for repeat of three");
  a_rpt_one: assert property (rpt_tk && rpt_count_in == RPT_W'(1) |=> !busy_out)
    else $error("busy after repeat of one");
  a_busy_cause: assert property ($rose(busy_out) |-> $past(rpt_tk))
    else $error("busy rose without repeat");
  a_rd_hold: assert property (!rd_valid_out && !$past(rst_in) |-> $stable(rd_data_out))
    else $error("read data moved without strobe");
endmodule : cad_checker

bind cad_datapath cad_checker #(.RPT_W(RPT_W)) u_chk (
  .ref_clk_in   (ref_clk_in),
  .rst_in       (rst_in),
  .op_valid_in  (op_valid_in),
  .op_code_in   (op_code_in),
  .mem_data_in  (mem_data_in),
  .rpt_count_in (rpt_count_in),
  .rd_data_out  (rd_data_out),
  .rd_valid_out (rd_valid_out),
  .crc_out      (crc_out),
  .busy_out     (busy_out)
);

// ### sim/cad_host_model.sv
/*
  Host core model: issues one instruction per cycle, waits out busy.
  Assumes the same clock as the datapath; driven by bench task calls.
*/
module cad_host_model (
  input  wire logic        ref_clk_in,
  input  wire logic        busy_in,
  output cad_pkg::cad_op_t op_code_out,
  output logic             op_valid_out,
  output logic [3:0]       dst_out,
  output logic [3:0]       src_a_out,
  output logic [3:0]       src_b_out,
  output logic [31:0]      mem_data_out,
  output logic [15:0]      rpt_count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    op_valid_out  = 1'b0;
    op_code_out   = cad_pkg::OP_NOP;
    {dst_out, src_a_out, src_b_out} = 12'hFFF;
    mem_data_out  = 32'h0;
    rpt_count_out = 16'h1;
  end

  task automatic issue(cad_pkg::cad_op_t c, logic [3:0] d, a, b, logic [31:0] m,
                       logic [15:0] n);
    @(posedge ref_clk_in);
    #1;
    while (busy_in !== 1'b0) begin
      op_valid_out = 1'b0;
      @(posedge ref_clk_in);
      #1;
    end
    {op_code_out, dst_out, src_a_out, src_b_out} = {c, d, a, b};
    mem_data_out  = m;
    rpt_count_out = n;
    op_valid_out  = 1'b1;
  endtask : issue

  // Operand for later repeat iterations
  task automatic feed(logic [31:0] m);
    @(posedge ref_clk_in);
    #1;
    op_valid_out = 1'b0;
    mem_data_out = m;
  endtask : feed

  // Released bus shows no stale operand
  task automatic idle();
    @(posedge ref_clk_in);
    #1;
    op_valid_out = 1'b0;
    mem_data_out = ~mem_data_out;
  endtask : idle
endmodule : cad_host_model

// ### sim/cad_datapath_tb.sv
/*
  Self-checking bench for the accelerator datapath.
  Assumes cad_host_model drives the instruction port and cad_checker is bound.
*/
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module cad_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             ref_clk_in;
  logic             rst_in;
  logic             op_valid;
  logic             busy;
  logic             rd_valid;
  cad_pkg::cad_op_t op_code;
  logic [3:0]       dst;
  logic [3:0]       sa;
  logic [3:0]       sb;
  logic [31:0]      mem;
  logic [31:0]      rd_data;
  logic [31:0]      crc;
  logic [15:0]      repeat_prefix;
  logic [31:0]      e;
  int               n_fail;
  int               check_count;
  int               cyc;

  cad_host_model host (.ref_clk_in(ref_clk_in), .busy_in(busy), .op_code_out(op_code),
    .op_valid_out(op_valid), .dst_out(dst), .src_a_out(sa), .src_b_out(sb),
    .mem_data_out(mem), .rpt_count_out(repeat_prefix));
  cad_datapath #(.RPT_W(16)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .op_valid_in(op_valid), .op_code_in(op_code), .dst_in(dst), .src_a_in(sa),
    .src_b_in(sb), .mem_data_in(mem), .rpt_count_in(repeat_prefix), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .crc_out(crc), .busy_out(busy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic op(cad_pkg::cad_op_t c, int d, int a, int b, logic [31:0] m, int n = 1);
    host.issue(c, 4'(d), 4'(a), 4'(b), m, 16'(n));
  endtask : op

  task automatic st_check(int idx, logic [31:0] x, string nm);
    op(cad_pkg::OP_ST32, 15, idx, 0, 32'h0);
    host.idle();
    `CHK("rd strobe", 1'b1, rd_valid)
    `CHK(nm, x, rd_data)
  endtask : st_check

  // MSB first unless reversed; width w
  function automatic logic [31:0] crc_ref(logic [31:0] c, p, int w, logic [7:0] d, logic f);
    logic [31:0] m;
    logic        b;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1;
    for (int i = 0; i < 8; i++) begin
      b = f ? d[i] : d[7-i];
      if (c[w-1] ^ b) c = ((c << 1) ^ p) & m;
      else c = (c << 1) & m;
    end
    return c;
  endfunction : crc_ref

  task automatic t_store();
    `CHK("crc reset", 32'h0, crc)
    `CHK("busy reset", 1'b0, busy)
    op(cad_pkg::OP_LD32, 2, 0, 0, 32'hBEEF_1234);
    st_check(2, 32'hBEEF_1234, "vr2");
    st_check(3, 32'h0, "vr3 untouched");
  endtask : t_store

  task automatic t_crc();
    for (int w = 8; w <= 32; w += 8) begin
      op(cad_pkg::OP_LDPOLY, 15, 0, 0, 32'h04C1_1DB7);
      op(cad_pkg::OP_LDSIZE, 15, 0, 0, {11'h0, 5'(w - 1), 16'h7});
      op(cad_pkg::OP_LDCRC, 15, 0, 0, 32'h0);
      op(cad_pkg::OP_CRCL, 15, 0, 0, 32'h0000_A53C);
      op(cad_pkg::OP_CRCH, 15, 0, 0, 32'h0000_A53C);
      e = crc_ref(crc_ref(32'h0, 32'h04C1_1DB7, w, 8'h3C, 1'b0), 32'h04C1_1DB7, w, 8'hA5, 1'b0);
      host.idle();
      `CHK("crc width", e, crc)
    end
    op(cad_pkg::OP_STCRC, 15, 0, 0, 32'h0);
    host.idle();
    `CHK("crc store", e, rd_data)
    op(cad_pkg::OP_SETCFG, 15, 0, 0, 32'h0000_0071);
    op(cad_pkg::OP_CRCL, 15, 0, 0, 32'h0000_003C);
    e = crc_ref(e, 32'h04C1_1DB7, 32, 8'h3C, 1'b1);
    host.idle();
    `CHK("crc reversed", e, crc)
    op(cad_pkg::OP_SETCFG, 15, 0, 0, 32'h0000_0070);
    op(cad_pkg::OP_LDCRC, 15, 0, 0, 32'h0);
    e = 32'h0;
    for (int i = 0; i < 10; i++) begin
      op(cad_pkg::OP_CRCL, 15, 0, 0, 32'(i * 17));
      e = crc_ref(e, 32'h04C1_1DB7, 32, 8'(i * 17), 1'b0);
    end
    host.idle();
    `CHK("crc ten bytes", e, crc)
    op(cad_pkg::OP_CRCSWAP, 15, 0, 0, 32'h0);
    host.idle();
    `CHK("crc swap", {e[31:16], e[7:0], e[15:8]}, crc)
  endtask : t_crc

  task automatic t_cplx();
    op(cad_pkg::OP_LD32, 0, 0, 0, 32'h0001_0000);
    op(cad_pkg::OP_LD32, 1, 0, 0, 32'h0000_0003);
    op(cad_pkg::OP_LD32, 2, 0, 0, 32'h0000_0010);
    op(cad_pkg::OP_LD32, 3, 0, 0, 32'hFFFF_FFFF);
    op(cad_pkg::OP_CADD32, 4, 0, 2, 32'h0);
    st_check(4, 32'h0001_0010, "cadd re");
    st_check(5, 32'h0000_0002, "cadd im");
    op(cad_pkg::OP_CSUB32, 6, 0, 2, 32'h0);
    st_check(6, 32'h0000_FFF0, "csub re");
    op(cad_pkg::OP_LD32, 0, 0, 0, 32'h0003_0005);
    op(cad_pkg::OP_CMPY, 2, 0, 0, 32'hFFFE_0007);
    host.idle();
    st_check(2, 32'h29, "cmpy re");
    st_check(3, 32'h0B, "cmpy im");
    op(cad_pkg::OP_CMAC, 2, 0, 0, 32'hFFFE_0007);
    host.idle();
    st_check(2, 32'h52, "cmac re");
    op(cad_pkg::OP_RPTMAC, 2, 0, 0, 32'hFFFE_0007, 3);
    host.feed(32'h0001_0001);
    host.feed(32'h0000_0002);
    host.idle();
    `CHK("busy after repeat", 1'b0, busy)
    st_check(2, 32'h87, "rpt re");
    st_check(3, 32'h2F, "rpt im");
    op(cad_pkg::OP_RPTMAC, 2, 0, 0, 32'hFFFE_0007, 1);
    host.idle();
    `CHK("busy single", 1'b0, busy)
    // Mixed add keeps 15 significant bits, sign extended
    op(cad_pkg::OP_LD32, 0, 0, 0, 32'h0008_0004);
    op(cad_pkg::OP_LD32, 4, 0, 0, 32'h000C_0000);
    op(cad_pkg::OP_LD32, 5, 0, 0, 32'h0004_0000);
    op(cad_pkg::OP_CADD16, 6, 0, 4, 32'h0);
    st_check(6, 32'h0003_0004, "cadd16");
    op(cad_pkg::OP_CSUB16, 6, 0, 4, 32'h0);
    st_check(6, 32'h0001_FFFE, "csub16");
  endtask : t_cplx

  task automatic t_vit();
    op(cad_pkg::OP_LD32, 0, 0, 0, 32'h0003_0009);
    op(cad_pkg::OP_BM2, 1, 0, 0, 32'h0);
    st_check(1, 32'h0006_000C, "bm2");
    op(cad_pkg::OP_LD32, 2, 0, 0, 32'h0000_0002);
    op(cad_pkg::OP_BM3, 7, 0, 2, 32'h0);
    st_check(7, 32'h0000_0004, "bm3 early");
    st_check(7, 32'h000A_000E, "bm3 p");
    st_check(8, 32'h0004_0008, "bm3 m");
    op(cad_pkg::OP_LD32, 0, 0, 0, 32'h0010_0005);
    op(cad_pkg::OP_LD32, 1, 0, 0, 32'h0000_0003);
    op(cad_pkg::OP_ACS, 4, 0, 1, 32'h0);
    host.idle();
    st_check(4, 32'h0013_000D, "acs");
    // Length 2 clamps to 4: state 5, decision bit 0 gives 2
    op(cad_pkg::OP_LD32, 5, 0, 0, 32'h0000_0005);
    op(cad_pkg::OP_SETCFG, 15, 0, 0, 32'h0000_0020);
    op(cad_pkg::OP_TRACE, 6, 5, 0, 32'h0);
    host.idle();
    st_check(6, 32'h0001_FFFE, "trace early");
    st_check(6, 32'h0000_0002, "trace state");
  endtask : t_vit

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // Hang guard, far above the run length
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    rst_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    t_store();
    t_crc();
    t_cplx();
    t_vit();
    final_report();
  end
endmodule : cad_datapath_tb
